// file: brc_pkg.sv
// constants and types shared by the chip control register bank
package brc_pkg;
    // register offset and field positions
    localparam logic [11:0] BRC_CC0_OFF  = 12'h040;
    localparam int          BRC_PF_LSB   = 8;
    localparam int          BRC_SDR_BIT  = 10;
    localparam int          BRC_MRBC_LSB = 12;
    localparam int          BRC_FC_BIT   = 15;
    localparam int          BRC_RCS_BIT  = 16;
    localparam int          BRC_RCL_LSB  = 17;
    localparam int          BRC_DTD_BIT  = 19;
    localparam int          BRC_DTS_BIT  = 20;
    localparam int          BRC_CRS_LSB  = 21;
    localparam int          BRC_ORD_BIT  = 23;
    localparam int          BRC_CPL_LSB  = 24;

    // values after reset
    localparam logic [1:0] BRC_PF_RST   = 2'h0;
    localparam logic [2:0] BRC_MRBC_RST = 3'h0;
    localparam logic [1:0] BRC_RCL_RST  = 2'h0;
    localparam logic [1:0] BRC_CRS_RST  = 2'h1;
    localparam logic [1:0] BRC_CPL_RST  = 2'h1;

    // prefetch policy codes
    localparam logic [1:0] BRC_PF_LINE = 2'h0;
    localparam logic [1:0] BRC_PF_FULL = 2'h2;
    localparam logic [1:0] BRC_PF_DISC = 2'h3;

    // read request byte counts
    localparam logic [12:0] BRC_BC_128  = 13'h0080;
    localparam logic [12:0] BRC_BC_256  = 13'h0100;
    localparam logic [12:0] BRC_BC_512  = 13'h0200;
    localparam logic [12:0] BRC_BC_1024 = 13'h0400;
    localparam logic [12:0] BRC_BC_2048 = 13'h0800;
    localparam logic [12:0] BRC_BC_4096 = 13'h1000;

    // retry limits, in retries
    localparam logic [31:0] BRC_RTRY_256 = 32'h0000_0100;
    localparam logic [31:0] BRC_RTRY_64K = 32'h0001_0000;
    localparam logic [31:0] BRC_RTRY_2G  = 32'h8000_0000;

    // discard timer lengths, in pci clocks
    localparam logic [31:0] BRC_DT_SHORT_CYC = 32'h0000_0040;
    localparam logic [31:0] BRC_DT_LONG_CYC  = 32'h0000_8000;
    localparam logic [31:0] BRC_DT_NORM_CYC  = 32'h0000_0400;

    // timeouts in 100 ns clocks: 25us, 0.5ms, 5ms, 25ms; 50us, 1ms, 10ms, 50ms
    localparam int BRC_CRS0_CYC = 250;
    localparam int BRC_CRS1_CYC = 5000;
    localparam int BRC_CRS2_CYC = 50000;
    localparam int BRC_CRS3_CYC = 250000;
    localparam int BRC_CPL0_CYC = 500;
    localparam int BRC_CPL1_CYC = 10000;
    localparam int BRC_CPL2_CYC = 100000;
    localparam int BRC_CPL3_CYC = 500000;

    // timer states
    typedef enum logic {
        BRC_TMR_IDLE = 1'b0,
        BRC_TMR_RUN  = 1'b1
    } brc_tmr_st_t;
endpackage

// file: brc_tmr_if.sv
// carrier between the register bank and one of its down-counters
`timescale 1ns/1ns
interface brc_tmr_if;
    logic        start;
    logic        stop;
    logic        tick;
    logic [31:0] limit;
    logic        expired;
    logic        busy;

    modport ctl (output start, output stop, output tick, output limit, input expired, input busy);
    modport tmr (input start, input stop, input tick, input limit, output expired, output busy);
endinterface

// file: brc_tmr.sv
// tick-driven down-counter with one-cycle expiry pulse
`timescale 1ns/1ns
module brc_tmr
    import brc_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    brc_tmr_if.tmr    tif
);
    typedef struct packed {
        brc_tmr_st_t st;
        logic [31:0] cnt;
        logic        exp;
    } brc_tmr_state_t;

    brc_tmr_state_t s_q;
    brc_tmr_state_t s_d;

    // stop beats start; a zero limit means the timer never arms
    always_comb begin
        s_d     = s_q;
        s_d.exp = 1'b0;
        if (tif.stop) begin
            s_d.st = BRC_TMR_IDLE;
        end else if (tif.start && (tif.limit != 32'h0000_0000)) begin
            s_d.st  = BRC_TMR_RUN;
            s_d.cnt = tif.limit;
        end else if ((s_q.st == BRC_TMR_RUN) && tif.tick) begin
            if (s_q.cnt == 32'h0000_0001) begin
                s_d.exp = 1'b1;
                s_d.st  = BRC_TMR_IDLE;
            end else begin
                s_d.cnt = s_q.cnt - 32'h0000_0001;
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{st: BRC_TMR_IDLE, cnt: 32'h0000_0000, exp: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign tif.expired = s_q.exp;
    assign tif.busy    = (s_q.st == BRC_TMR_RUN);
endmodule

// file: brc_ctrl.sv
// chip control register bits 8..25: read, retry and timer control for the bridge
//
// Function
// [R1] - bits 9:8 pick prefetch: 00 one line, 10 full, 11 disconnect first dword
// [R2] - special delayed read clear: retry a master that changes its command code
// [R3] - special delayed read set: accept MR/MRL/MRM swaps if address and enables match
// [R4] - bits 14:12 map to 128..4096 bytes; 000, 011, 111 mean 512
// [R5] - byte count applies only to upstream reads when full prefetch is selected
// [R6] - bit 15 clear: flow control update per two credits; set: per credit
// [R7] - bits 18:17 retry limit: unlimited, 256, 64K, 2G
// [R8] - bit 16 sticks once retry counter expired; software writes one to clear
// [R9] - bit 19 with bridge control bit 27 disables the discard timer
// [R10] - bit 20 forces a 64 clock discard timer, else bridge control picks
// [R11] - bits 22:21 config retry timeout 25us, 0.5ms, 5ms, 25ms; resets 01
// [R12] - bit 23 set forces delayed transactions to complete in order
// [R13] - bits 25:24 completion timeout 50us, 1ms, 10ms, 50ms; resets 01
// [R14] - bit 11 reads zero and ignores writes
`timescale 1ns/1ns
module brc_ctrl
    import brc_pkg::*;
#(
    parameter int unsigned DT_LONG_CYC = BRC_DT_LONG_CYC,
    parameter int unsigned CRS1_CYC    = BRC_CRS1_CYC,
    parameter int unsigned CRS2_CYC    = BRC_CRS2_CYC,
    parameter int unsigned CRS3_CYC    = BRC_CRS3_CYC,
    parameter int unsigned CPL1_CYC    = BRC_CPL1_CYC,
    parameter int unsigned CPL2_CYC    = BRC_CPL2_CYC,
    parameter int unsigned CPL3_CYC    = BRC_CPL3_CYC
)(
    input  wire logic        clk,
    input  wire logic        rst_n,
    // configuration space access
    input  wire logic        cfg_wr,
    input  wire logic        cfg_rd,
    input  wire logic [11:0] cfg_addr,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    output logic      [31:0] cfg_rdata,
    // bridge control bits and orientation
    input  wire logic        bctl_dt_dis,
    input  wire logic        bctl_dt_pri_sel,
    input  wire logic        bctl_dt_sec_sel,
    input  wire logic        reverse_mode,
    // prefetch and read request sizing
    output logic      [1:0]  pf_mode,
    output logic             pf_full,
    output logic             pf_disc_first_dw,
    output logic      [12:0] mrd_max_bytes,
    output logic             mrd_cap_en,
    // repeated delayed read check
    input  wire logic        rpt_valid,
    input  wire logic        rpt_cmd_same,
    input  wire logic        rpt_cmd_memrd,
    input  wire logic        rpt_addr_be_same,
    output logic             sdr_en,
    output logic             rpt_accept,
    output logic             rpt_retry,
    // flow control credits
    input  wire logic        credit_freed,
    output logic             fc_update,
    // retry counter
    input  wire logic        retry_issued,
    input  wire logic        retry_done,
    output logic             retry_expired,
    // discard, config retry and completion timers
    input  wire logic        dt_start,
    input  wire logic        dt_stop,
    output logic             dt_enable,
    output logic             dt_expired,
    input  wire logic        crs_start,
    input  wire logic        crs_stop,
    output logic             crs_expired,
    input  wire logic        cpl_start,
    input  wire logic        cpl_stop,
    output logic             cpl_expired,
    output logic             dt_in_order
);
    typedef struct packed {
        logic [1:0]  pf;
        logic        sdr;
        logic [2:0]  mrbc;
        logic        fc_one;
        logic        rc_sts;
        logic [1:0]  rc_lim;
        logic        dt_dis;
        logic        dt_short;
        logic [1:0]  crs_sel;
        logic        order;
        logic [1:0]  cpl_sel;
        logic        fc_pend;
        logic        fc_upd;
        logic [31:0] rdata;
    } brc_state_t;

    brc_state_t s_q;
    brc_state_t s_d;

    brc_tmr_if rtry_if ();
    brc_tmr_if dt_if ();
    brc_tmr_if crs_if ();
    brc_tmr_if cpl_if ();

    logic        hit;
    logic [31:0] rd_word;
    logic [31:0] rtry_lim;
    logic [31:0] dt_lim;
    logic [31:0] crs_lim;
    logic [31:0] cpl_lim;

    ////////////////////////////////////////////////////////////////////////
    // decode of the stored fields

    assign hit = (cfg_addr[11:2] == BRC_CC0_OFF[11:2]);

    // bit 11 and the fields owned elsewhere read as zero
    always_comb begin
        rd_word                                  = 32'h0000_0000;
        rd_word[BRC_PF_LSB+1:BRC_PF_LSB]         = s_q.pf;
        rd_word[BRC_SDR_BIT]                     = s_q.sdr;
        rd_word[BRC_MRBC_LSB+2:BRC_MRBC_LSB]     = s_q.mrbc;
        rd_word[BRC_FC_BIT]                      = s_q.fc_one;
        rd_word[BRC_RCS_BIT]                     = s_q.rc_sts;
        rd_word[BRC_RCL_LSB+1:BRC_RCL_LSB]       = s_q.rc_lim;
        rd_word[BRC_DTD_BIT]                     = s_q.dt_dis;
        rd_word[BRC_DTS_BIT]                     = s_q.dt_short;
        rd_word[BRC_CRS_LSB+1:BRC_CRS_LSB]       = s_q.crs_sel;
        rd_word[BRC_ORD_BIT]                     = s_q.order;
        rd_word[BRC_CPL_LSB+1:BRC_CPL_LSB]       = s_q.cpl_sel; // [R14]
    end

    // byte count table; the unused codes fold onto 512
    always_comb begin
        unique case (s_q.mrbc)
            3'h1:    mrd_max_bytes = BRC_BC_128;  // [R4]
            3'h2:    mrd_max_bytes = BRC_BC_256;
            3'h4:    mrd_max_bytes = BRC_BC_1024;
            3'h5:    mrd_max_bytes = BRC_BC_2048;
            3'h6:    mrd_max_bytes = BRC_BC_4096;
            default: mrd_max_bytes = BRC_BC_512;
        endcase
    end

    // retry limit; one less is loaded since the first retry arms the count
    always_comb begin
        unique case (s_q.rc_lim)
            2'h0: rtry_lim = 32'h0000_0000; // [R7]
            2'h1: rtry_lim = BRC_RTRY_256 - 32'h0000_0001;
            2'h2: rtry_lim = BRC_RTRY_64K - 32'h0000_0001;
            2'h3: rtry_lim = BRC_RTRY_2G - 32'h0000_0001;
        endcase
    end

    // discard timer length: short override, else bridge control per orientation
    always_comb begin
        if (s_q.dt_short) begin
            dt_lim = BRC_DT_SHORT_CYC; // [R10]
        end else if (reverse_mode ? bctl_dt_sec_sel : bctl_dt_pri_sel) begin
            dt_lim = 32'(DT_LONG_CYC);
        end else begin
            dt_lim = BRC_DT_NORM_CYC;
        end
    end

    // timeout selections
    always_comb begin
        unique case (s_q.crs_sel)
            2'h0: crs_lim = 32'(BRC_CRS0_CYC);  // [R11]
            2'h1: crs_lim = 32'(CRS1_CYC);
            2'h2: crs_lim = 32'(CRS2_CYC);
            2'h3: crs_lim = 32'(CRS3_CYC);
        endcase
        unique case (s_q.cpl_sel)
            2'h0: cpl_lim = 32'(BRC_CPL0_CYC);  // [R13]
            2'h1: cpl_lim = 32'(CPL1_CYC);
            2'h2: cpl_lim = 32'(CPL2_CYC);
            2'h3: cpl_lim = 32'(CPL3_CYC);
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // next state: writes, sticky status, credit pairing, read data

    always_comb begin
        s_d        = s_q;
        s_d.fc_upd = 1'b0;
        if (cfg_rd) begin
            s_d.rdata = hit ? rd_word : 32'h0000_0000;
        end
        if (cfg_wr && hit) begin
            if (cfg_be[1]) begin
                s_d.pf     = cfg_wdata[BRC_PF_LSB+1:BRC_PF_LSB]; // [R1]
                s_d.sdr    = cfg_wdata[BRC_SDR_BIT]; // [R2]
                s_d.mrbc   = cfg_wdata[BRC_MRBC_LSB+2:BRC_MRBC_LSB]; // [R4]
                s_d.fc_one = cfg_wdata[BRC_FC_BIT]; // [R6]
            end
            if (cfg_be[2]) begin
                if (cfg_wdata[BRC_RCS_BIT]) begin
                    s_d.rc_sts = 1'b0; // [R8]
                end
                s_d.rc_lim   = cfg_wdata[BRC_RCL_LSB+1:BRC_RCL_LSB]; // [R7]
                s_d.dt_dis   = cfg_wdata[BRC_DTD_BIT]; // [R9]
                s_d.dt_short = cfg_wdata[BRC_DTS_BIT]; // [R10]
                s_d.crs_sel  = cfg_wdata[BRC_CRS_LSB+1:BRC_CRS_LSB]; // [R11]
                s_d.order    = cfg_wdata[BRC_ORD_BIT]; // [R12]
            end
            if (cfg_be[3]) begin
                s_d.cpl_sel = cfg_wdata[BRC_CPL_LSB+1:BRC_CPL_LSB];  // [R13]
            end
        end
        // an expiry in the clearing cycle still sets the flag
        if (rtry_if.expired) begin
            s_d.rc_sts = 1'b1; // [R8]
        end
        // credits pair up unless single-credit updates are selected
        if (credit_freed) begin
            if (s_q.fc_one || s_q.fc_pend) begin
                s_d.fc_upd  = 1'b1; // [R6]
                s_d.fc_pend = 1'b0;
            end else begin
                s_d.fc_pend = 1'b1;
            end
        end
        // a pending odd credit is flushed once single-credit mode is chosen
        if (s_q.fc_one && s_q.fc_pend && !credit_freed) begin
            s_d.fc_upd  = 1'b1;
            s_d.fc_pend = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{pf: BRC_PF_RST, sdr: 1'b0, mrbc: BRC_MRBC_RST, fc_one: 1'b0,
                     rc_sts: 1'b0, rc_lim: BRC_RCL_RST, dt_dis: 1'b0, dt_short: 1'b0,
                     crs_sel: BRC_CRS_RST, order: 1'b0, cpl_sel: BRC_CPL_RST,
                     fc_pend: 1'b0, fc_upd: 1'b0, rdata: 32'h0000_0000};
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // timers

    // retry counter: counts retries, not clocks
    assign rtry_if.start = retry_issued && !rtry_if.busy; // [R7]
    assign rtry_if.stop  = retry_done;
    assign rtry_if.tick  = retry_issued;
    assign rtry_if.limit = rtry_lim;

    // discard timer is held off while either disable is set
    assign dt_enable   = !s_q.dt_dis && !bctl_dt_dis; // [R9]
    assign dt_if.start = dt_start && dt_enable;
    assign dt_if.stop  = dt_stop || !dt_enable;
    assign dt_if.tick  = 1'b1;
    assign dt_if.limit = dt_lim;

    assign crs_if.start = crs_start;
    assign crs_if.stop  = crs_stop;
    assign crs_if.tick  = 1'b1;
    assign crs_if.limit = crs_lim;

    assign cpl_if.start = cpl_start;
    assign cpl_if.stop  = cpl_stop;
    assign cpl_if.tick  = 1'b1;
    assign cpl_if.limit = cpl_lim;

    brc_tmr u_rtry (.clk(clk), .rst_n(rst_n), .tif(rtry_if));
    brc_tmr u_dt   (.clk(clk), .rst_n(rst_n), .tif(dt_if));
    brc_tmr u_crs  (.clk(clk), .rst_n(rst_n), .tif(crs_if));
    brc_tmr u_cpl  (.clk(clk), .rst_n(rst_n), .tif(cpl_if));

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // prefetch policy and upstream request cap
    assign pf_mode          = s_q.pf; // [R1]
    assign pf_full          = (s_q.pf == BRC_PF_FULL);
    assign pf_disc_first_dw = (s_q.pf == BRC_PF_DISC);
    assign mrd_cap_en       = pf_full; // [R5]

    // a changed command is only forgiven in special delayed read mode
    assign sdr_en     = s_q.sdr;
    assign rpt_accept = rpt_valid && rpt_addr_be_same &&
                        (rpt_cmd_same || (s_q.sdr && rpt_cmd_memrd)); // [R3]
    assign rpt_retry  = rpt_valid && !rpt_accept; // [R2]

    assign cfg_rdata     = s_q.rdata;
    assign fc_update     = s_q.fc_upd;
    assign retry_expired = rtry_if.expired;
    assign dt_expired    = dt_if.expired;
    assign crs_expired   = crs_if.expired;
    assign cpl_expired   = cpl_if.expired;
    assign dt_in_order   = s_q.order; // [R12]
endmodule

// file: brc_ctrl_monitor.sv
// assertions watching the chip control bank ports
`timescale 1ns/1ns
module brc_ctrl_monitor
    import brc_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        cfg_wr,
    input wire logic        cfg_rd,
    input wire logic [11:0] cfg_addr,
    input wire logic [3:0]  cfg_be,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic        bctl_dt_dis,
    input wire logic [1:0]  pf_mode,
    input wire logic        pf_full,
    input wire logic        pf_disc_first_dw,
    input wire logic        mrd_cap_en,
    input wire logic        rpt_valid,
    input wire logic        rpt_cmd_same,
    input wire logic        rpt_cmd_memrd,
    input wire logic        rpt_addr_be_same,
    input wire logic        sdr_en,
    input wire logic        rpt_accept,
    input wire logic        rpt_retry,
    input wire logic        credit_freed,
    input wire logic        fc_update,
    input wire logic        retry_expired,
    input wire logic        dt_start,
    input wire logic        dt_enable,
    input wire logic        dt_expired,
    input wire logic        crs_start,
    input wire logic        crs_expired,
    input wire logic        dt_in_order
);
    logic stk_q;
    wire  wr40 = cfg_wr && cfg_addr[11:2] == 10'h010;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////
    // sticky mirror; clear wins so it never runs ahead of the flag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stk_q <= 1'b0;
        end else if (wr40 && cfg_be[2] && cfg_wdata[16]) begin
            stk_q <= 1'b0;
        end else if (retry_expired) begin
            stk_q <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////
    a_pf_decode: assert property (
        pf_full == (pf_mode == 2'h2) && pf_disc_first_dw == (pf_mode == 2'h3) && mrd_cap_en == pf_full)
        else $error("prefetch decode wrong");
    a_rpt_answer: assert property (
        rpt_accept == (rpt_valid && rpt_addr_be_same && (rpt_cmd_same || (sdr_en && rpt_cmd_memrd)))
        && rpt_retry == (rpt_valid && !rpt_accept)) else $error("repeat answer wrong");
    a_fc_cause: assert property (
        fc_update |-> $past(credit_freed) || $past(cfg_wr) || $past(cfg_wr, 2)) else $error("stray update");
    a_rx_pulse: assert property (
        retry_expired |=> !retry_expired) else $error("expiry longer than a cycle");
    a_sticky_flag: assert property (
        cfg_rd && stk_q |=> cfg_rdata[16]) else $error("retry status lost");
    a_dt_gate: assert property (
        bctl_dt_dis |-> !dt_enable) else $error("discard timer not gated");
    a_dt_min: assert property (
        dt_start |=> !dt_expired [*8]) else $error("discard timer too short");
    a_crs_min: assert property (
        crs_start |=> !crs_expired [*8]) else $error("config retry timer too short");
    a_ord_write: assert property (
        wr40 && cfg_be[2] |=> dt_in_order == $past(cfg_wdata[23])) else $error("order bit not written");
endmodule
bind brc_ctrl brc_ctrl_monitor brc_ctrl_monitor_inst (.*);

// file: brc_link_mdl.sv
// far side model: link freeing credits, pci masters taking retries
`timescale 1ns/1ns
module brc_link_mdl
    import brc_pkg::*;
(
    input  wire logic clk,
    output logic      credit_freed,
    output logic      retry_issued,
    output logic      retry_done
);
    // idle levels; callers enter every task at a falling edge
    initial begin
        {credit_freed, retry_issued, retry_done} = 3'h0;
    end
    // gap must be at least one so the strobe is never lowered and raised together
    task automatic credits(input int n, input int gap);
        repeat (n) begin
            credit_freed = 1'b1;
            @(negedge clk);
            credit_freed = 1'b0;
            repeat (gap) @(negedge clk);
        end
    endtask
    // back to back retries, held high for n edges
    task automatic retries(input int n);
        retry_issued = 1'b1;
        repeat (n) @(negedge clk);
        retry_issued = 1'b0;
        @(negedge clk);
    endtask
    task automatic done();
        retry_done = 1'b1;
        @(negedge clk);
        retry_done = 1'b0;
        @(negedge clk);
    endtask
endmodule

// file: brc_ctrl_test.sv
// self-checking bench for the chip control register bank
`timescale 1ns/1ns
module brc_ctrl_test
    import brc_pkg::*;
;
    logic        clk, rst_n, cfg_wr, cfg_rd, bctl_dt_dis, bctl_dt_pri_sel, bctl_dt_sec_sel, reverse_mode;
    logic        rpt_valid, rpt_cmd_same, rpt_cmd_memrd, rpt_addr_be_same, pf_full, pf_disc_first_dw;
    logic        mrd_cap_en, sdr_en, rpt_accept, rpt_retry, credit_freed, fc_update, acc;
    logic        retry_issued, retry_done, retry_expired, dt_enable, dt_in_order;
    logic [11:0] cfg_addr, ra;
    logic [3:0]  cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata, sh, rv, rnd;
    logic [2:0]  st, sp;
    logic [1:0]  pf_mode;
    logic [12:0] mrd_max_bytes;
    wire  [2:0]  ex;
    int          n_fail, total_checks, n_fc, n_rx, n_ex, cyc;

    ////////////////////////////////////////////////////////////
    // bank under test with long counts shortened
    brc_ctrl #(.DT_LONG_CYC(90), .CRS1_CYC(30), .CRS2_CYC(40), .CRS3_CYC(50), .CPL1_CYC(60), .CPL2_CYC(70),
        .CPL3_CYC(80)) brc_ctrl_inst (.clk, .rst_n, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata,
        .cfg_rdata, .bctl_dt_dis, .bctl_dt_pri_sel, .bctl_dt_sec_sel, .reverse_mode, .pf_mode, .pf_full,
        .pf_disc_first_dw, .mrd_max_bytes, .mrd_cap_en, .rpt_valid, .rpt_cmd_same, .rpt_cmd_memrd,
        .rpt_addr_be_same, .sdr_en, .rpt_accept, .rpt_retry, .credit_freed, .fc_update, .retry_issued,
        .retry_done, .retry_expired, .dt_start(st[0]), .dt_stop(sp[0]), .dt_enable, .dt_expired(ex[0]),
        .crs_start(st[1]), .crs_stop(sp[1]), .crs_expired(ex[1]), .cpl_start(st[2]), .cpl_stop(sp[2]),
        .cpl_expired(ex[2]), .dt_in_order);
    brc_link_mdl brc_link_mdl_inst (.clk, .credit_freed, .retry_issued, .retry_done);

    ////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // pulse counters and the hang limit
    always @(posedge clk) begin
        cyc++;
        if (fc_update === 1'b1) n_fc++;
        if (retry_expired === 1'b1) n_rx++;
        if (ex !== 3'h0) n_ex++;
        if (cyc == 20000) begin
            n_fail++;
            print_verdict();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [12:0] exp_bc(input logic [2:0] c);
        case (c)
            3'h1: return BRC_BC_128;
            3'h2: return BRC_BC_256;
            3'h4: return BRC_BC_1024;
            3'h5: return BRC_BC_2048;
            3'h6: return BRC_BC_4096;
            default: return BRC_BC_512;
        endcase
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // shadow holds writable bits only
    task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & 32'h03FE_F700;
        if (a[11:2] == 10'h010) sh = (sh & ~m) | (d & m);
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = d;
        cfg_wr = 1'b1;
        @(negedge clk);
        cfg_wr = 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [11:0] a);
        cfg_addr = a;
        cfg_rd = 1'b1;
        @(negedge clk);
        cfg_rd = 1'b0;
        rv = cfg_rdata;
    endtask
    task automatic setf(input int lsb, input int w, input logic [31:0] v);
        wr(12'h040, 4'hF, (sh & ~(((32'h1 << w) - 1) << lsb)) | (v << lsb));
    endtask
    task automatic tmr(input int k, input int e);
        int n;
        st[k] = 1'b1;
        @(negedge clk);
        st[k] = 1'b0;
        n = 0;
        while (ex[k] !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        chk("timer length", e, n);
    endtask
    task automatic print_verdict();
        if (n_fail == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {rst_n, cfg_wr, cfg_rd, bctl_dt_dis, bctl_dt_pri_sel, bctl_dt_sec_sel, reverse_mode, st, sp} = '0;
        {rpt_valid, rpt_cmd_same, rpt_cmd_memrd, rpt_addr_be_same} = 4'h0;
        {cfg_addr, cfg_be, cfg_wdata} = {12'h040, 36'h0};
        sh = 32'h0120_0000;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        rd(12'h040);
        chk("reset value", 32'h0120_0000, rv);
        chk("reset bytes", BRC_BC_512, mrd_max_bytes);
        // random writes over random lanes, a few off the register
        rnd = 32'h61;
        for (int i = 0; i < 40; i++) begin
            rnd = lfsr(rnd);
            ra = (rnd[2:0] == 3'h0) ? rnd[15:4] : 12'h040;
            wr(ra, rnd[7:4], lfsr(rnd));
            rd(ra);
            chk("read back", (ra[11:2] == 10'h010) ? sh : 32'h0, rv);
            chk("fields", {sh[9:8], sh[10], sh[23]}, {pf_mode, sdr_en, dt_in_order});
            chk("byte count", exp_bc(sh[14:12]), mrd_max_bytes);
        end
        for (int c = 0; c < 8; c++) begin
            setf(BRC_MRBC_LSB, 3, c);
            chk("byte code", exp_bc(c[2:0]), mrd_max_bytes);
        end
        for (int c = 0; c < 4; c++) begin
            setf(BRC_PF_LSB, 2, c);
            chk("prefetch", {c[1:0] == 2'h2, c[1:0] == 2'h3}, {pf_full, pf_disc_first_dw});
            chk("cap enable", c[1:0] == 2'h2, mrd_cap_en);
        end
        // every repeat combination in both delayed read modes
        for (int i = 0; i < 32; i++) begin
            setf(BRC_SDR_BIT, 1, i[4]);
            {rpt_valid, rpt_cmd_same, rpt_cmd_memrd, rpt_addr_be_same} = i[3:0];
            #1;
            acc = i[3] && i[0] && (i[2] || (i[4] && i[1]));
            chk("repeat", {acc, i[3] && !acc}, {rpt_accept, rpt_retry});
        end
        rpt_valid = 1'b0;
        // credit updates: pairs, flush of the odd credit, then singles
        setf(BRC_FC_BIT, 1, 0);
        n_fc = 0;
        brc_link_mdl_inst.credits(5, 2);
        repeat (3) @(negedge clk);
        chk("fc per two", 2, n_fc);
        setf(BRC_FC_BIT, 1, 1);
        repeat (3) @(negedge clk);
        chk("fc flush", 3, n_fc);
        brc_link_mdl_inst.credits(2, 1);
        repeat (3) @(negedge clk);
        chk("fc per one", 5, n_fc);
        // retry limit: unlimited, then exactly 256
        n_rx = 0;
        setf(BRC_RCL_LSB, 2, 0);
        brc_link_mdl_inst.retries(300);
        brc_link_mdl_inst.done();
        setf(BRC_RCL_LSB, 2, 1);
        brc_link_mdl_inst.retries(255);
        chk("no expiry yet", 0, n_rx);
        brc_link_mdl_inst.retries(1);
        repeat (2) @(negedge clk);
        chk("expiry count", 1, n_rx);
        setf(BRC_RCL_LSB, 2, 0);
        rd(12'h040);
        chk("status set", 1, rv[16]);
        wr(12'h040, 4'h4, 32'h0001_0000);
        rd(12'h040);
        chk("status cleared", 0, rv[16]);
        // discard timer gating and lengths
        setf(BRC_DTD_BIT, 1, 1);
        chk("dt gate bit", 0, dt_enable);
        setf(BRC_DTD_BIT, 1, 0);
        bctl_dt_dis = 1'b1;
        #1 chk("dt gate bridge", 0, dt_enable);
        bctl_dt_dis = 1'b0;
        #1 chk("dt gate open", 1, dt_enable);
        for (int c = 0; c < 4; c++) begin
            setf(BRC_DTS_BIT, 1, c == 0);
            {reverse_mode, bctl_dt_pri_sel, bctl_dt_sec_sel} = c[1] ? {1'b1, ~c[0], c[0]} : {2'b00, c[0]} << 1;
            tmr(0, c == 0 ? BRC_DT_SHORT_CYC : (c == 2 ? BRC_DT_NORM_CYC : 90));
        end
        // config retry and completion timeouts for every code
        for (int c = 0; c < 4; c++) begin
            setf(BRC_CRS_LSB, 2, c);
            tmr(1, c ? 20 + 10 * c : BRC_CRS0_CYC);
            setf(BRC_CPL_LSB, 2, c);
            tmr(2, c ? 50 + 10 * c : BRC_CPL0_CYC);
        end
        // a stop pulse after the start silences all three timers
        st = 3'h7;
        @(negedge clk);
        {st, sp} = 6'h07;
        @(negedge clk);
        sp = 3'h0;
        n_ex = 0;
        repeat (100) @(negedge clk);
        chk("stopped timers", 0, n_ex);
        print_verdict();
    end
endmodule
